/* File: sptc_pkg.sv */
// package: shared types and constants of the sample period trigger controller
package sptc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] SPTC_CTRL_OFS   = 12'h000;
  localparam logic [11:0] SPTC_THRESH_OFS = 12'h004;
  localparam logic [11:0] SPTC_PERIOD_OFS = 12'h008;
  localparam logic [11:0] SPTC_STATUS_OFS = 12'h00C;
  localparam logic [11:0] SPTC_COUNT_OFS  = 12'h010;

  // ----------------------------------------------------------------
  // control field positions
  // ----------------------------------------------------------------
  localparam int SPTC_CTRL_MODE_LSB   = 0;
  localparam int SPTC_CTRL_OUT_BIT    = 2;
  localparam int SPTC_CTRL_FILT_LSB   = 4;
  localparam int SPTC_CTRL_AUTO_BIT   = 6;
  localparam int SPTC_CTRL_ENA_BIT    = 7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  // threshold in signed whole dBm, one lsb per dB
  localparam logic signed [7:0] SPTC_THRESH_RST = -8'sd15;
  localparam logic [31:0] SPTC_PERIOD_RST     = 32'h0000_0400;
  localparam logic [7:0]  SPTC_AUTO_LEVEL     = 8'hC4;
  localparam logic [31:0] SPTC_BAD_RDATA      = 32'h0000_0000;

  typedef enum logic [1:0] {SPTC_TRIG_FREE, SPTC_TRIG_INT, SPTC_TRIG_RISE,
                            SPTC_TRIG_FALL} sptc_trig_mode_t;
  typedef enum logic [1:0] {SPTC_FILT_CW, SPTC_FILT_1M5, SPTC_FILT_5M,
                            SPTC_FILT_OFF} sptc_filt_t;

  typedef struct packed {
    logic            enable;
    logic            auto_level;
    sptc_filt_t      filt;
    logic            spare;
    logic            out_trig;
    sptc_trig_mode_t mode;
  } sptc_ctrl_t;

  localparam sptc_ctrl_t SPTC_CTRL_RST = '{enable: 1'b0, auto_level: 1'b0,
    filt: SPTC_FILT_OFF, spare: 1'b0, out_trig: 1'b1, mode: SPTC_TRIG_FREE};

endpackage

/* File: sptc_sync.sv */
// module: three-stage pin synchroniser with agreement filter
module sptc_sync
  import sptc_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin,
  output logic      level
);

  logic [2:0] sync_reg;
  logic       level_reg;
  wire        agree = (sync_reg[2] == sync_reg[1]);

  // sync_reg[0] is read only by sync_reg[1]
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_reg  <= 3'h0;
      level_reg <= 1'b0;
    end
    else
    begin
      sync_reg  <= {sync_reg[1:0], pin};
      if (agree)
        level_reg <= sync_reg[2];
    end
  end

  assign level = level_reg;

endmodule

/* File: sptc_edge.sv */
// module: single-cycle edge detector on a synchronised level
module sptc_edge
  import sptc_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic level,
  output logic      rise,
  output logic      fall
);

  logic prev_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prev_reg <= 1'b0;
    else
      prev_reg <= level;
  end

  assign rise = level & ~prev_reg;
  assign fall = ~level & prev_reg;

endmodule

/* File: sptc_top.sv */
// module: sample period trigger controller with APB register slave
//
// Overview of operation
// (RULE_01) free mode: next period starts right after previous data packet is sent
// (RULE_02) internal mode: after period ends, wait for qualifying RF to start next
// (RULE_03) external rise mode: period starts on low-to-high trigger input edge
// (RULE_04) external fall mode: period starts on high-to-low trigger input edge
// (RULE_05) triggers arriving during an active period are discarded entirely
// (RULE_06) combined output is inverted video or trigger falling at pulse start
// (RULE_07) video output path bypasses analysis and filtering stages
// (RULE_08) settable threshold in 1 dB steps, -15 dBm after reset
// (RULE_09) settable threshold fires only on rising crossing of the level
// (RULE_10) automatic level variant triggers on rising edge of significant RF
// (RULE_11) filter select: CW, 1.5 MHz, 5 MHz or off for widest bandwidth
// (RULE_12) external trigger synchronised before edge detection, one pulse per edge
//
// The implementer's own choices: the APB register port and the register offsets.
module sptc_top
  import sptc_pkg::*;
#(
  parameter int DET_W = 8
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              trig_in,
  input  wire logic signed [DET_W-1:0] det_level,
  input  wire logic [DET_W-1:0]  video_raw,
  input  wire logic [DET_W-1:0]  video_filt,
  input  wire logic              pkt_done,
  output logic                   period_active,
  output logic                   period_start,
  output logic      [DET_W-1:0]  out_video,
  output logic                   out_trig,
  output logic                   out_is_video,
  output sptc_filt_t             filt_sel
);

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  sptc_ctrl_t        ctrl_reg;
  logic signed [7:0] thresh_reg;
  logic [31:0]       period_reg;
  logic [31:0]       count_reg;
  logic [31:0]       starts_reg;
  logic [31:0]       prdata_reg;

  wire acc      = psel & penable;
  wire wr       = acc & pwrite;
  wire hit_ctrl = (paddr == SPTC_CTRL_OFS);
  wire hit_thr  = (paddr == SPTC_THRESH_OFS);
  wire hit_per  = (paddr == SPTC_PERIOD_OFS);
  wire hit_sts  = (paddr == SPTC_STATUS_OFS);
  wire hit_cnt  = (paddr == SPTC_COUNT_OFS);
  wire mapped   = hit_ctrl | hit_thr | hit_per | hit_sts | hit_cnt;
  wire ro_hit   = hit_sts | hit_cnt;

  assign pready  = 1'b1;
  assign pslverr = acc & (~mapped | (pwrite & ro_hit));

  // read mux kept combinational, then registered for stable data
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = SPTC_BAD_RDATA;
    if (hit_ctrl)
      rd_mux = {24'h0, ctrl_reg};
    else if (hit_thr)
      rd_mux = {{24{thresh_reg[7]}}, thresh_reg};
    else if (hit_per)
      rd_mux = period_reg;
    else if (hit_sts)
      rd_mux = {30'h0, out_trig, period_active};
    else if (hit_cnt)
      rd_mux = starts_reg;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_reg <= 32'h0000_0000;
    else if (psel & ~penable & ~pwrite)
      prdata_reg <= rd_mux;
  end
  assign prdata = prdata_reg;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg   <= SPTC_CTRL_RST;
      thresh_reg <= SPTC_THRESH_RST;  // see RULE_08
      period_reg <= SPTC_PERIOD_RST;
    end
    else if (wr & pstrb[0])
    begin
      if (hit_ctrl)
        ctrl_reg <= sptc_ctrl_t'({pwdata[7:4], 1'b0, pwdata[2:0]});  // see RULE_11
      if (hit_thr)
        thresh_reg <= signed'(pwdata[7:0]);  // see RULE_08
      if (hit_per)
        period_reg <= pwdata;
    end
  end

  // ----------------------------------------------------------------
  // trigger sources
  // ----------------------------------------------------------------
  logic ext_lvl;
  logic ext_rise;
  logic ext_fall;

  sptc_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (trig_in),
    .level   (ext_lvl)
  );  // see RULE_12

  sptc_edge u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .level   (ext_lvl),
    .rise    (ext_rise),
    .fall    (ext_fall)
  );  // see RULE_12

  // rf above level, registered; rising crossing only
  logic              rf_above_reg;
  logic signed [7:0] lvl_use;
  assign lvl_use = ctrl_reg.auto_level ? signed'(SPTC_AUTO_LEVEL) : thresh_reg;  // see RULE_10
  wire rf_above = (det_level >= DET_W'(lvl_use));
  wire rf_rise  = rf_above & ~rf_above_reg;  // see RULE_09

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rf_above_reg <= 1'b1;  // no false trigger straight out of reset
    else
      rf_above_reg <= rf_above;
  end

  // ----------------------------------------------------------------
  // period sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SPTC_IDLE, SPTC_RUN, SPTC_SEND} sptc_state_t;
  sptc_state_t state_reg;
  sptc_state_t state_next;

  logic start_cond;
  always_comb
  begin
    unique case (ctrl_reg.mode)
      SPTC_TRIG_FREE: start_cond = 1'b1;  // see RULE_01
      SPTC_TRIG_INT:  start_cond = rf_rise;  // see RULE_02
      SPTC_TRIG_RISE: start_cond = ext_rise;  // see RULE_03
      SPTC_TRIG_FALL: start_cond = ext_fall;  // see RULE_04
    endcase
  end

  wire period_end = (count_reg >= period_reg);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      SPTC_IDLE:
        if (ctrl_reg.enable & start_cond)
          state_next = SPTC_RUN;
      // triggers in run or send are never looked at
      SPTC_RUN:
        if (period_end)
          state_next = SPTC_SEND;  // see RULE_05
      SPTC_SEND:
        if (pkt_done)
          state_next = SPTC_IDLE;
    endcase
  end

  assign period_start = (state_reg == SPTC_IDLE) & (state_next == SPTC_RUN);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg  <= SPTC_IDLE;
      count_reg  <= 32'h0000_0000;
      starts_reg <= 32'h0000_0000;
    end
    else
    begin
      state_reg <= state_next;
      if (period_start)
      begin
        count_reg  <= 32'h0000_0001;
        starts_reg <= starts_reg + 32'h0000_0001;
      end
      else if (state_reg == SPTC_RUN)
        count_reg <= count_reg + 32'h0000_0001;
    end
  end

  assign period_active = (state_reg != SPTC_IDLE);

  // ----------------------------------------------------------------
  // combined output and filter
  // ----------------------------------------------------------------
  logic [DET_W-1:0] out_video_reg;
  logic             out_trig_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_video_reg <= '0;
      out_trig_reg  <= 1'b1;
    end
    else
    begin
      // raw path, not the filtered one, for widest bandwidth
      out_video_reg <= ctrl_reg.out_trig ? '0 : ~video_raw;  // see RULE_06, see RULE_07
      // low while the pulse is present, so falling edge marks its start
      out_trig_reg  <= ctrl_reg.out_trig ? ~rf_above : 1'b1;  // see RULE_06
    end
  end

  assign out_video    = out_video_reg;
  assign out_trig     = out_trig_reg;
  assign out_is_video = ~ctrl_reg.out_trig;
  assign filt_sel     = ctrl_reg.filt;  // see RULE_11

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_free_start;
    @(posedge pclk) disable iff (!presetn)
    (state_reg == SPTC_SEND && pkt_done && ctrl_reg.mode == SPTC_TRIG_FREE
     && ctrl_reg.enable) |=> ##1 period_active;
  endproperty
  a_free_start: assert property (p_free_start) else $error("free run gap"); // see RULE_01

  property p_int_wait;
    @(posedge pclk) disable iff (!presetn)
    (period_start && ctrl_reg.mode == SPTC_TRIG_INT) |-> rf_rise;
  endproperty
  a_int_wait: assert property (p_int_wait) else $error("internal start without rf"); // see RULE_02

  property p_rise_start;
    @(posedge pclk) disable iff (!presetn)
    (period_start && ctrl_reg.mode == SPTC_TRIG_RISE) |-> ext_lvl && !$past(ext_lvl);
  endproperty
  a_rise_start: assert property (p_rise_start) else $error("rise start bad"); // see RULE_03

  property p_fall_start;
    @(posedge pclk) disable iff (!presetn)
    (period_start && ctrl_reg.mode == SPTC_TRIG_FALL) |-> !ext_lvl && $past(ext_lvl);
  endproperty
  a_fall_start: assert property (p_fall_start) else $error("fall start bad"); // see RULE_04

  property p_ignore_busy;
    @(posedge pclk) disable iff (!presetn)
    (state_reg == SPTC_RUN && !period_end) |=> state_reg == SPTC_RUN;
  endproperty
  a_ignore_busy: assert property (p_ignore_busy) else $error("period cut short"); // see RULE_05

  property p_video_out;
    @(posedge pclk) disable iff (!presetn)
    (!ctrl_reg.out_trig ##1 !$past(ctrl_reg.out_trig)) |-> out_video == ~$past(video_raw);
  endproperty
  a_video_out: assert property (p_video_out) else $error("video not raw inverted"); // see RULE_07

  property p_trig_out;
    @(posedge pclk) disable iff (!presetn)
    (ctrl_reg.out_trig && rf_rise) |=> !out_trig;
  endproperty
  a_trig_out: assert property (p_trig_out) else $error("trigger out not low"); // see RULE_06

  property p_rf_rising;
    @(posedge pclk) disable iff (!presetn)
    rf_rise |-> !$past(rf_above);
  endproperty
  a_rf_rising: assert property (p_rf_rising) else $error("rf trigger not rising"); // see RULE_09

  property p_sync_one;
    @(posedge pclk) disable iff (!presetn)
    ext_rise |=> !ext_rise;
  endproperty
  a_sync_one: assert property (p_sync_one) else $error("double edge pulse"); // see RULE_12

  property p_run_end;
    @(posedge pclk) disable iff (!presetn)
    (state_reg == SPTC_RUN && period_end) |=> state_reg == SPTC_SEND;
  endproperty
  a_run_end: assert property (p_run_end) else $error("period overran"); // see RULE_01

  property p_send_hold;
    @(posedge pclk) disable iff (!presetn)
    (state_reg == SPTC_SEND && !pkt_done) |=> state_reg == SPTC_SEND;
  endproperty
  a_send_hold: assert property (p_send_hold) else $error("left send early"); // see RULE_01

  property p_busy_no_start;
    @(posedge pclk) disable iff (!presetn)
    period_active |-> !period_start;
  endproperty
  a_busy_no_start: assert property (p_busy_no_start) else $error("start while busy"); // see RULE_05

  property p_thresh_step;
    @(posedge pclk) disable iff (!presetn)
    (wr && hit_thr && pstrb[0]) |=> thresh_reg == signed'($past(pwdata[7:0]));
  endproperty
  a_thresh_step: assert property (p_thresh_step) else $error("threshold not stored"); // see RULE_08

  property p_auto_level;
    @(posedge pclk) disable iff (!presetn)
    (ctrl_reg.auto_level && rf_rise) |-> det_level >= DET_W'(signed'(SPTC_AUTO_LEVEL));
  endproperty
  a_auto_level: assert property (p_auto_level) else $error("auto trigger too low"); // see RULE_10

  property p_trig_idle;
    @(posedge pclk) disable iff (!presetn)
    (ctrl_reg.out_trig && !rf_above) |=> out_trig;
  endproperty
  a_trig_idle: assert property (p_trig_idle) else $error("trigger out not idle"); // see RULE_06

  property p_filt_write;
    @(posedge pclk) disable iff (!presetn)
    (wr && hit_ctrl && pstrb[0]) |=> filt_sel == sptc_filt_t'($past(pwdata[5:4]));
  endproperty
  a_filt_write: assert property (p_filt_write) else $error("filter not stored"); // see RULE_11

  property p_fall_one;
    @(posedge pclk) disable iff (!presetn)
    ext_fall |=> !ext_fall;
  endproperty
  a_fall_one: assert property (p_fall_one) else $error("double fall pulse"); // see RULE_12

endmodule

/* File: sptc_fe_model.sv */
// partner model: external trigger source and rf detector front end
module sptc_fe_model
  import sptc_pkg::*;
#(
  parameter int DET_W = 8
)
(
  output logic                    trig_in,
  output logic signed [DET_W-1:0] det_level,
  output logic [DET_W-1:0]        video_raw,
  output logic [DET_W-1:0]        video_filt,
  output logic                    pkt_done
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    trig_in = 1'b0;
    det_level = 8'hB0;
    video_raw = 8'h00;
    pkt_done = 1'b1;
  end

  // filtered copy differs on purpose, so a path that skips the bypass shows up
  assign video_filt = video_raw ^ 8'h5A;

  // pkt_done held low models a slow packet sender
  task automatic set_p(input logic p);
    pkt_done <= p;
  endtask
  task automatic set_t(input logic t);
    trig_in <= t;
  endtask
  task automatic set_d(input logic signed [DET_W-1:0] d);
    det_level <= d;
  endtask
  task automatic set_v(input logic [DET_W-1:0] v);
    video_raw <= v;
  endtask
endmodule

/* File: tb.sv */
// testbench: apb-driven scenarios for the sample period trigger controller
module tb
  import sptc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DW = 8;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic                 trig_in, pkt_done, period_active, period_start, out_trig, out_is_video;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, q;
  logic [3:0]           pstrb;
  logic signed [DW-1:0] det_level;
  logic [DW-1:0]        video_raw, video_filt, out_video;
  sptc_filt_t           filt_sel;
  int                   err_total, tests_run, starts;

  sptc_top #(.DET_W(DW)) sptc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig_in(trig_in),
    .det_level(det_level), .video_raw(video_raw), .video_filt(video_filt),
    .pkt_done(pkt_done), .period_active(period_active), .period_start(period_start),
    .out_video(out_video), .out_trig(out_trig), .out_is_video(out_is_video),
    .filt_sel(filt_sel));
  sptc_fe_model #(.DET_W(DW)) sptc_fe_model_i (.trig_in(trig_in), .det_level(det_level),
    .video_raw(video_raw), .video_filt(video_filt), .pkt_done(pkt_done));

  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  always @(posedge pclk)
    if (period_start === 1'b1)
      starts <= starts + 1;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      err_total++;
      wrap_up();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input string n, input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    cmp(n, x, q);
  endtask

  // fixed window: counts starts seen over k cycles
  task automatic nstart(input int k, input int x);
    int s0;
    s0 = starts;
    repeat (k) @(posedge pclk);
    cmp("starts", x, starts - s0);
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    err_total++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    {err_total, tests_run} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rc("ctrl", SPTC_CTRL_OFS, 32'h0000_0034);
    rc("thresh", SPTC_THRESH_OFS, 32'hFFFF_FFF1);
    rc("period", SPTC_PERIOD_OFS, 32'h0000_0400);
    wr(12'h020, 32'h0000_0001);
    cmp("slverr", 32'h1, e);
    rc("unmapped", 12'h020, 32'h0);
    wr(SPTC_THRESH_OFS, 32'h0000_00ED);
    rc("thresh", SPTC_THRESH_OFS, 32'hFFFF_FFED);
    pstrb <= 4'hE;
    wr(SPTC_THRESH_OFS, 32'h0000_0001);
    pstrb <= 4'hF;
    rc("thresh", SPTC_THRESH_OFS, 32'hFFFF_FFED);
    wr(SPTC_COUNT_OFS, 32'h0000_0001);
    cmp("slverr", 32'h1, e);
    rc("count", SPTC_COUNT_OFS, 32'h0);
    $display("test registers done");
    wr(SPTC_PERIOD_OFS, 32'h0000_0008);
    sptc_fe_model_i.set_p(1'b0);
    wr(SPTC_CTRL_OFS, 32'h0000_00B4);
    nstart(30, 1);
    sptc_fe_model_i.set_p(1'b1);
    nstart(4, 1);
    $display("test free done");
    wr(SPTC_CTRL_OFS, 32'h0000_00B6);
    repeat (20) @(posedge pclk);
    nstart(40, 0);
    sptc_fe_model_i.set_t(1'b1);
    nstart(2, 0);
    nstart(6, 1);
    repeat (20) @(posedge pclk);
    sptc_fe_model_i.set_t(1'b0);
    nstart(20, 0);
    wr(SPTC_CTRL_OFS, 32'h0000_00B7);
    sptc_fe_model_i.set_t(1'b1);
    nstart(20, 0);
    sptc_fe_model_i.set_t(1'b0);
    nstart(8, 1);
    repeat (10) @(posedge pclk);
    rc("status", SPTC_STATUS_OFS, 32'h0000_0002);
    rc("count", SPTC_COUNT_OFS, starts);
    $display("test edges done");
    wr(SPTC_PERIOD_OFS, 32'h0000_003C);
    wr(SPTC_CTRL_OFS, 32'h0000_00B6);
    sptc_fe_model_i.set_t(1'b1);
    nstart(8, 1);
    cmp("active", 32'h1, period_active);
    rc("status", SPTC_STATUS_OFS, 32'h0000_0003);
    sptc_fe_model_i.set_t(1'b0);
    repeat (5) @(posedge pclk);
    sptc_fe_model_i.set_t(1'b1);
    nstart(80, 0);
    sptc_fe_model_i.set_t(1'b0);
    repeat (10) @(posedge pclk);
    sptc_fe_model_i.set_t(1'b1);
    nstart(8, 1);
    repeat (70) @(posedge pclk);
    $display("test ignore done");
    // -30 dBm below the -19 dBm level, then -10 dBm above it
    wr(SPTC_PERIOD_OFS, 32'h0000_0008);
    sptc_fe_model_i.set_d(8'hE2);
    wr(SPTC_CTRL_OFS, 32'h0000_00B5);
    nstart(20, 0);
    cmp("out_trig", 32'h1, out_trig);
    cmp("out_is_video", 32'h0, out_is_video);
    sptc_fe_model_i.set_d(8'hF6);
    nstart(6, 1);
    nstart(30, 0);
    cmp("out_trig", 32'h0, out_trig);
    sptc_fe_model_i.set_d(8'hE2);
    nstart(20, 0);
    // automatic level: -70 dBm then -40 dBm
    wr(SPTC_CTRL_OFS, 32'h0000_00F5);
    sptc_fe_model_i.set_d(8'hBA);
    nstart(20, 0);
    sptc_fe_model_i.set_d(8'hD8);
    nstart(6, 1);
    $display("test internal done");
    sptc_fe_model_i.set_v(8'h3C);
    wr(SPTC_CTRL_OFS, 32'h0000_00B0);
    repeat (4) @(posedge pclk);
    cmp("out_video", 32'hC3, out_video);
    cmp("out_is_video", 32'h1, out_is_video);
    cmp("out_trig", 32'h1, out_trig);
    for (int i = 0; i < 4; i++)
    begin
      wr(SPTC_CTRL_OFS, 32'h0000_0084 | (i << 4));
      repeat (2) @(posedge pclk);
      cmp("filt_sel", i, filt_sel);
    end
    $display("test output done");
    wrap_up();
  end
endmodule
